// ==== rtl/fpes_pkg.sv ====
// Package for the flash program/erase sequencer: operation codes, sizes,
// field layouts and carrier structs.
// Assumes a single 40 MHz clock and a flash array with a 128-bit data path.
package fpes_pkg;

  localparam int unsigned OP_W      = 4;
  localparam int unsigned ADDR_W    = 24;   // Byte address into the array
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned QUAD_W    = 128;
  localparam int unsigned NUM_HOLD  = 4;    // Write-data holding words
  localparam int unsigned HOLD_IDX_W = 2;

  // Operation codes
  localparam logic [3:0] OP_NOP     = 4'h0;
  localparam logic [3:0] OP_WORD    = 4'h1;
  localparam logic [3:0] OP_QUAD    = 4'h2;
  localparam logic [3:0] OP_ROW     = 4'h3;
  localparam logic [3:0] OP_PAGE    = 4'h4;
  localparam logic [3:0] OP_LOWER   = 4'h5;
  localparam logic [3:0] OP_UPPER   = 4'h6;
  localparam logic [3:0] OP_ALL     = 4'h7;
  localparam logic [3:0] OP_RSV_MIN = 4'h8;

  // Row is 2 KB = 512 words; page is 16 KB = 4K words
  localparam int unsigned ROW_BYTES  = 2048;
  localparam int unsigned ROW_WORDS  = 512;
  localparam int unsigned PAGE_BYTES = 16384;
  localparam int unsigned PAGE_WORDS = 4096;
  localparam int unsigned CNT_W      = 13;
  localparam logic [CNT_W-1:0] ROW_QUADS  = 13'h0080; // 512 words / 4
  localparam logic [CNT_W-1:0] PAGE_QUADS = 13'h0400; // 4096 words / 4

  // Address alignment masks
  localparam logic [ADDR_W-1:0] WORD_ALIGN = 24'hFFFFFC;
  localparam logic [ADDR_W-1:0] QUAD_ALIGN = 24'hFFFFF0;
  localparam logic [ADDR_W-1:0] ROW_ALIGN  = 24'hFFF800;
  localparam logic [ADDR_W-1:0] PAGE_ALIGN = 24'hFFC000;
  localparam logic [ADDR_W-1:0] QUAD_STEP  = 24'h000010;
  localparam logic [ADDR_W-1:0] WORD_STEP  = 24'h000004;
  localparam logic [ADDR_W-1:0] HALF_BASE  = 24'h000000;
  localparam logic [ADDR_W-1:0] UPPER_BASE = 24'h800000;

  // Flash array command kinds
  localparam logic [1:0] FCMD_PROG  = 2'h1;
  localparam logic [1:0] FCMD_ERASE = 2'h2;

  // Software control inputs
  typedef struct packed {
    logic                  op_wr;        // Write strobe for the op code
    logic [OP_W-1:0]       op_wdata;
    logic                  permit;       // Flash write permit bit
    logic                  start;        // Launch the stored operation
    logic                  data_wr;      // Holding word write strobe
    logic [HOLD_IDX_W-1:0] data_idx;
    logic [WORD_W-1:0]     data_wdata;
    logic [ADDR_W-1:0]     addr;         // Target flash byte address
  } fpes_ctrl_s;

  // Request to the flash array
  typedef struct packed {
    logic              valid;
    logic [1:0]        kind;
    logic [ADDR_W-1:0] addr;
    logic [QUAD_W-1:0] data;
    logic [3:0]        word_en;          // Word lanes written
    logic [CNT_W-1:0]  length;           // Quad words to erase, 0 = whole
  } fpes_flash_req_s;

endpackage : fpes_pkg

// ==== rtl/fpes_hold_regs.sv ====
// Four 32-bit write-data holding words for program operations.
// Assumes writes come synchronous to clock_i.
`timescale 1ns/100ps
module fpes_hold_regs (
  input  wire logic                               clock_i,
  input  wire logic                               arst_n_i,
  input  wire logic                               wr_i,
  input  wire logic [fpes_pkg::HOLD_IDX_W-1:0]    idx_i,
  input  wire logic [fpes_pkg::WORD_W-1:0]        wdata_i,
  output logic      [fpes_pkg::QUAD_W-1:0]        quad_o
);

  logic [fpes_pkg::WORD_W-1:0] word_q [fpes_pkg::NUM_HOLD];
  logic [fpes_pkg::WORD_W-1:0] word_d [fpes_pkg::NUM_HOLD];

  genvar g;
  generate
    for (g = 0; g < fpes_pkg::NUM_HOLD; g++) begin : g_word
      always_comb begin
        word_d[g] = word_q[g];
        if (wr_i && idx_i == fpes_pkg::HOLD_IDX_W'(g)) begin
          word_d[g] = wdata_i;
        end
      end
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          word_q[g] <= 32'h0000_0000;
        end else begin
          word_q[g] <= word_d[g];
        end
      end
      // Word 0 sits in the low lane, which maps to the lowest address
      assign quad_o[g*fpes_pkg::WORD_W +: fpes_pkg::WORD_W] = word_q[g];
    end
  endgenerate

  AST_HOLD_WRITE: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    wr_i |=> quad_o[$past(idx_i)*fpes_pkg::WORD_W +: fpes_pkg::WORD_W]
      == $past(wdata_i))
    else $error("Holding word did not take written data");

endmodule // fpes_hold_regs

// ==== rtl/fpes_sequencer.sv ====
// Flash program/erase sequencer top: op code register, holding words and
// the request sequencing toward the flash array.
// Assumes a flash array that takes one request per ready cycle.
`timescale 1ns/100ps
module fpes_sequencer (
  input  wire logic                            clock_i,
  input  wire logic                            arst_n_i,
  input  wire fpes_pkg::fpes_ctrl_s            ctrl_i,
  input  wire logic                            flash_ready_i,
  output fpes_pkg::fpes_flash_req_s            flash_req_o,
  output logic [fpes_pkg::OP_W-1:0]            flash_operation_code_o,
  output logic                                 busy_o,
  output logic                                 op_error_o
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT  = 3'b100
  } fpes_state_e;

  function automatic logic is_row(input logic [3:0] op);
    return op == fpes_pkg::OP_ROW;
  endfunction

  function automatic logic is_valid_op(input logic [3:0] op);
    return op != fpes_pkg::OP_NOP && op < fpes_pkg::OP_RSV_MIN;
  endfunction

  logic [fpes_pkg::QUAD_W-1:0]   quad_data;
  fpes_state_e                   state_q, state_d;
  logic [3:0]                    op_q, op_d;
  logic [fpes_pkg::CNT_W-1:0]    cnt_q, cnt_d;
  logic [fpes_pkg::ADDR_W-1:0]   addr_q, addr_d;
  fpes_pkg::fpes_flash_req_s     req_q, req_d;
  logic                          busy_q, busy_d;
  logic                          err_q, err_d;

  fpes_hold_regs u_hold (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .wr_i     (ctrl_i.data_wr && !busy_q),
    .idx_i    (ctrl_i.data_idx),
    .wdata_i  (ctrl_i.data_wdata),
    .quad_o   (quad_data)
  );

  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    req_d   = req_q;
    busy_d  = busy_q;
    err_d   = err_q;
    // Locking the op code while busy keeps a running sequence coherent
    if (ctrl_i.op_wr && ctrl_i.permit && !busy_q) begin
      op_d = ctrl_i.op_wdata;
    end
    case (state_q)
      ST_IDLE: begin
        if (ctrl_i.start) begin
          err_d = !is_valid_op(op_q) && op_q != fpes_pkg::OP_NOP;
          if (is_valid_op(op_q) && ctrl_i.permit) begin
            busy_d  = 1'b1;
            state_d = ST_ISSUE;
            req_d.word_en = 4'hF;
            req_d.length  = 13'h0001;
            case (op_q)
              fpes_pkg::OP_WORD: begin
                req_d.kind    = fpes_pkg::FCMD_PROG;
                addr_d        = ctrl_i.addr & fpes_pkg::WORD_ALIGN;
                req_d.word_en = 4'h1 << addr_d[3:2];
                cnt_d         = 13'h0001;
              end
              fpes_pkg::OP_QUAD: begin
                req_d.kind = fpes_pkg::FCMD_PROG;
                addr_d     = ctrl_i.addr & fpes_pkg::QUAD_ALIGN;
                cnt_d      = 13'h0001;
              end
              fpes_pkg::OP_ROW: begin
                req_d.kind = fpes_pkg::FCMD_PROG;
                addr_d     = ctrl_i.addr & fpes_pkg::ROW_ALIGN;
                cnt_d      = fpes_pkg::ROW_QUADS;
              end
              fpes_pkg::OP_PAGE: begin
                req_d.kind   = fpes_pkg::FCMD_ERASE;
                addr_d       = ctrl_i.addr & fpes_pkg::PAGE_ALIGN;
                req_d.length = fpes_pkg::PAGE_QUADS;
                cnt_d        = 13'h0001;
              end
              fpes_pkg::OP_LOWER: begin
                req_d.kind   = fpes_pkg::FCMD_ERASE;
                addr_d       = fpes_pkg::HALF_BASE;
                req_d.length = 13'h0000;
                cnt_d        = 13'h0001;
              end
              fpes_pkg::OP_UPPER: begin
                req_d.kind   = fpes_pkg::FCMD_ERASE;
                addr_d       = fpes_pkg::UPPER_BASE;
                req_d.length = 13'h0000;
                cnt_d        = 13'h0001;
              end
              default: begin
                req_d.kind   = fpes_pkg::FCMD_ERASE;
                addr_d       = fpes_pkg::HALF_BASE;
                req_d.length = 13'h0000;
                req_d.word_en = 4'h0;
                cnt_d        = 13'h0001;
              end
            endcase
          end
        end
      end
      ST_ISSUE: begin
        req_d.valid = 1'b1;
        req_d.addr  = addr_q;
        // Single-word program still passes the full lane set; the
        // word enable selects which holding word lands
        req_d.data  = quad_data;
        state_d     = ST_WAIT;
      end
      ST_WAIT: begin
        if (flash_ready_i) begin
          req_d.valid = 1'b0;
          cnt_d       = cnt_q - 13'h0001;
          if (cnt_q == 13'h0001) begin
            busy_d  = 1'b0;
            state_d = ST_IDLE;
          end else begin
            // Row program streams the holding words per quad slot
            addr_d  = addr_q + fpes_pkg::QUAD_STEP;
            state_d = ST_ISSUE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d  = 1'b0;
        req_d.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      op_q    <= 4'h0;
      cnt_q   <= 13'h0000;
      addr_q  <= 24'h000000;
      req_q   <= '0;
      busy_q  <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      req_q   <= req_d;
      busy_q  <= busy_d;
      err_q   <= err_d;
    end
  end

  assign flash_req_o            = req_q;
  assign flash_operation_code_o = op_q;
  assign busy_o                 = busy_q;
  assign op_error_o             = err_q;

  AST_OP_PROTECT: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (!ctrl_i.permit || busy_o) |=> $stable(flash_operation_code_o))
    else $error("Op code changed without write permit");

  AST_OP_TAKEN: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (ctrl_i.op_wr && ctrl_i.permit && !busy_o)
      |=> flash_operation_code_o == $past(ctrl_i.op_wdata))
    else $error("Permitted op code write lost");

  AST_NOP_IDLE: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (ctrl_i.start && !busy_o && !is_valid_op(flash_operation_code_o))
      |=> !busy_o)
    else $error("Nop or reserved code started a sequence");

  AST_QUAD_ALIGN: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    $rose(flash_req_o.valid) && op_q == fpes_pkg::OP_QUAD
      |-> flash_req_o.addr[3:0] == 4'h0 && flash_req_o.word_en == 4'hF)
    else $error("Quad program not aligned or not full");

  AST_PAGE_LEN: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    $rose(flash_req_o.valid) && op_q == fpes_pkg::OP_PAGE
      |-> flash_req_o.length == fpes_pkg::PAGE_QUADS
          && flash_req_o.addr[13:0] == 14'h0000)
    else $error("Page erase wrong size or alignment");

  AST_ROW_ALIGN: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    $rose(busy_o) && is_row(op_q) |-> cnt_q == fpes_pkg::ROW_QUADS
      && addr_q[10:0] == 11'h000)
    else $error("Row program wrong length or alignment");

  AST_WORD_KIND: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    $rose(busy_o) && op_q == fpes_pkg::OP_WORD
      |-> ##1 flash_req_o.valid && flash_req_o.kind == fpes_pkg::FCMD_PROG
          && $countones(flash_req_o.word_en) == 1)
    else $error("Word program request malformed");

  AST_ERASE_KIND: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    $rose(busy_o) && op_q >= fpes_pkg::OP_PAGE
      |-> ##1 flash_req_o.kind == fpes_pkg::FCMD_ERASE)
    else $error("Erase code did not issue erase");

  // A quad must reach the array as one unchanged unit while it waits
  AST_REQ_HOLD: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    flash_req_o.valid && !flash_ready_i
      |=> flash_req_o.valid && $stable(flash_req_o.addr)
          && $stable(flash_req_o.data))
    else $error("Request changed before the array took it");

  COV_QUAD: cover property (@(posedge clock_i)
    $rose(busy_o) && op_q == fpes_pkg::OP_QUAD);
  COV_ROW_DONE: cover property (@(posedge clock_i)
    $fell(busy_o) && is_row(op_q));
  COV_DENIED: cover property (@(posedge clock_i)
    ctrl_i.op_wr && !ctrl_i.permit);
  COV_ALL_ERASE: cover property (@(posedge clock_i)
    $rose(busy_o) && op_q == fpes_pkg::OP_ALL);

endmodule // fpes_sequencer

// ==== test/fpes_flash_model.sv ====
// Flash array model: takes sequencer requests, promptly or slowly.
// Assumes one outstanding request, valid held until ready.
`timescale 1ns/100ps
module fpes_flash_model (
  input  wire logic                      clock_i,
  input  wire logic                      arst_n_i,
  input  wire fpes_pkg::fpes_flash_req_s req_i,
  input  wire logic                      slow_i,
  output logic                           ready_o,
  output logic [15:0]                    cnt_o,
  output fpes_pkg::fpes_flash_req_s      last_o
);
  logic [1:0] wait_q;
  // Ready is a one-cycle pulse so a request is never taken twice
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_o <= 1'b0;
      wait_q  <= 2'h0;
      cnt_o   <= 16'h0000;
      last_o  <= '0;
    end else begin
      if (ready_o && req_i.valid) begin
        cnt_o  <= cnt_o + 16'h0001;
        last_o <= req_i;
      end
      ready_o <= !ready_o && req_i.valid && (!slow_i || wait_q == 2'h3);
      wait_q  <= (ready_o || !req_i.valid) ? 2'h0
                 : wait_q + {1'b0, wait_q != 2'h3};
    end
  end
endmodule // fpes_flash_model

// ==== test/test_flash_program_erase_sequencer.sv ====
// Testbench for the flash program/erase sequencer.
// Assumes the flash model in fpes_flash_model.sv.
`timescale 1ns/100ps
module test_flash_program_erase_sequencer;
  logic                      clock_i  = 1'b0;
  logic                      arst_n_i = 1'b0;
  logic                      slow     = 1'b0;
  logic                      ready;
  logic                      busy;
  logic                      err;
  logic [3:0]                code;
  logic [15:0]               cnt;
  logic [15:0]               c0;
  fpes_pkg::fpes_ctrl_s      ctrl = '0;
  fpes_pkg::fpes_flash_req_s req;
  fpes_pkg::fpes_flash_req_s last;
  int                        error_cnt = 0;
  int                        tests_run = 0;

  always #12.5 clock_i = ~clock_i;

  fpes_sequencer dut_u (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .ctrl_i(ctrl),
    .flash_ready_i(ready), .flash_req_o(req),
    .flash_operation_code_o(code), .busy_o(busy), .op_error_o(err));

  fpes_flash_model flash_u (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .req_i(req),
    .slow_i(slow), .ready_o(ready), .cnt_o(cnt), .last_o(last));

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic set_op(input logic [3:0] op, input logic pm);
    @(negedge clock_i);
    ctrl.permit = pm;
    ctrl.op_wdata = op;
    ctrl.op_wr = 1'b1;
    @(negedge clock_i);
    ctrl.op_wr = 1'b0;
  endtask

  task automatic hold(input logic [1:0] i, input logic [31:0] v);
    @(negedge clock_i);
    ctrl.data_idx = i;
    ctrl.data_wdata = v;
    ctrl.data_wr = 1'b1;
    @(negedge clock_i);
    ctrl.data_wr = 1'b0;
  endtask

  // Polling is bounded; the watchdog also guards a stuck busy
  task automatic go(input logic [23:0] a);
    int n;
    c0 = cnt;
    @(negedge clock_i);
    ctrl.addr = a;
    ctrl.start = 1'b1;
    @(negedge clock_i);
    ctrl.start = 1'b0;
    @(negedge clock_i);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clock_i);
      n++;
    end
  endtask

  task automatic t_permit();
    set_op(fpes_pkg::OP_QUAD, 1'b0);
    chk(code, fpes_pkg::OP_NOP);
    set_op(fpes_pkg::OP_QUAD, 1'b1);
    chk(code, fpes_pkg::OP_QUAD);
    $display("done permit");
  endtask

  task automatic t_quad();
    for (int i = 0; i < 4; i++) hold(i[1:0], 32'hA0A00000 | i);
    set_op(fpes_pkg::OP_QUAD, 1'b1);
    go(24'h12345C);
    chk(cnt - c0, 16'h0001);
    chk(last.addr, 24'h123450);
    chk(last.data, 128'hA0A00003A0A00002A0A00001A0A00000);
    chk(last.word_en, 4'hF);
    chk(last.kind, fpes_pkg::FCMD_PROG);
    set_op(fpes_pkg::OP_WORD, 1'b1);
    go(24'h000108);
    chk(cnt - c0, 16'h0001);
    chk(last.word_en, 4'h4);
    chk(last.kind, fpes_pkg::FCMD_PROG);
    $display("done quad and word");
  endtask

  // Slow array; writes while busy must leave code and data alone
  task automatic t_row();
    slow = 1'b1;
    set_op(fpes_pkg::OP_ROW, 1'b1);
    fork
      go(24'h001804);
      begin
        repeat (6) @(negedge clock_i);
        set_op(fpes_pkg::OP_PAGE, 1'b1);
        hold(2'h0, 32'h00000000);
      end
    join
    slow = 1'b0;
    chk(cnt - c0, 16'h0080);
    chk(last.addr, 24'h001FF0);
    chk(last.data, 128'hA0A00003A0A00002A0A00001A0A00000);
    chk(code, fpes_pkg::OP_ROW);
    $display("done row");
  endtask

  task automatic t_erase();
    logic [23:0] ea [4] = '{24'h018000, 24'h000000, 24'h800000, 24'h000000};
    logic [12:0] el [4] = '{13'h0400, 13'h0000, 13'h0000, 13'h0000};
    for (int k = 0; k < 4; k++) begin
      set_op(fpes_pkg::OP_PAGE + k[3:0], 1'b1);
      go(24'h01ABCD);
      chk(cnt - c0, 16'h0001);
      chk(last.kind, fpes_pkg::FCMD_ERASE);
      chk(last.addr, ea[k]);
      chk(last.length, el[k]);
    end
    $display("done erase");
  endtask

  task automatic t_reserved();
    // Code 0 between two reserved codes shows the error flag clearing
    logic [3:0] cs [3] = '{4'h8, 4'h0, 4'hF};
    for (int k = 0; k < 3; k++) begin
      set_op(cs[k], 1'b1);
      go(24'h000000);
      chk(cnt - c0, 16'h0000);
      chk(err, cs[k] >= fpes_pkg::OP_RSV_MIN);
    end
    $display("done reserved");
  endtask

  task automatic end_sim();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(25 * 30000);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge clock_i);
    chk({busy, req.valid, code}, 6'h00);
    @(negedge clock_i);
    arst_n_i = 1'b1;
    t_permit();
    t_quad();
    t_row();
    t_erase();
    t_reserved();
    end_sim();
  end
endmodule // test_flash_program_erase_sequencer
